// *** src/xb_pkg.sv ***
// constants shared by the crossbar switch: register map, field layout, reset values
// assumes an apb3 master with 32-bit data and byte addresses
package xb_pkg;
  localparam int XB_PORTS = 32;
  localparam int XB_HALF = 32;
  localparam int XB_FIFO_DEPTH = 8;
  localparam int XB_ADDR_W = 8;
  localparam logic [7:0] XB_OFF_CTRL = 8'h00;
  localparam logic [7:0] XB_OFF_CMD = 8'h04;
  localparam logic [7:0] XB_OFF_STATUS = 8'h08;
  localparam logic [7:0] XB_OFF_VIEW = 8'h0C;
  localparam logic [7:0] XB_OFF_ROUTE = 8'h10;
  localparam int XB_CTRL_HOLD_BIT = 0;
  localparam int XB_CMD_OUT_LSB = 0;
  localparam int XB_CMD_IN_LSB = 8;
  localparam int XB_CMD_DIS_BIT = 16;
  localparam int XB_CMD_STAGE_BIT = 24;
  localparam int XB_CMD_COMMIT_BIT = 25;
  localparam int XB_CMD_CLEAR_BIT = 26;
  localparam int XB_CMD_CS_BIT = 31;
  localparam int XB_ST_CNT_LSB = 0;
  localparam int XB_ST_EMPTY_BIT = 8;
  localparam int XB_ST_FULL_BIT = 9;
  localparam int XB_RT_ACT_SEL_LSB = 0;
  localparam int XB_RT_ACT_DIS_BIT = 8;
  localparam int XB_RT_STG_SEL_LSB = 16;
  localparam int XB_RT_STG_DIS_BIT = 24;
  localparam logic XB_RST_DIS = 1'b1;
  localparam logic XB_RST_HOLD = 1'b0;
endpackage : xb_pkg

// *** src/xb_switch.sv ***
// crossbar switch with staged/active route registers, apb slave and command fifo
// assumes one clock pclk, inputs synchronous to it, apb3 master
//
// Decided for this implementation: the APB slave port and the placing of the registers.
`timescale 1ns/1ps

module xb_fifo #(
  parameter int W = 32,
  parameter int D = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data,
  output logic [$clog2(D):0] level
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp_reg;
  logic [AW-1:0] rp_reg;
  logic [AW:0] cnt_reg;
  logic push;
  logic pop;
  assign in_ready = (cnt_reg != (AW+1)'(D));
  assign out_valid = (cnt_reg != '0);
  assign out_data = mem[rp_reg];
  assign level = cnt_reg;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
    end else if (ce) begin
      if (push) begin
        wp_reg <= (wp_reg == AW'(D-1)) ? '0 : wp_reg + 1'b1;
      end
      if (pop) begin
        rp_reg <= (rp_reg == AW'(D-1)) ? '0 : rp_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  always_ff @(posedge clk) begin
    if (ce && push) begin
      mem[wp_reg] <= in_data;
    end
  end
endmodule : xb_fifo

// Summary of operation
// R1 - any output can route any input, and one input can feed many outputs at once.
// R2 - each output has its own wide multiplexer steered by its active selection.
// R3 - each output has its own enable, driven or released apart from the others.
// R4 - a staging write happens only when the stage strobe and select enable are both set.
// R5 - the output address of a staging write picks exactly one port's staged register.
// R6 - a staging write captures the input address and disable flag into that port.
// R7 - the active selection steers the port's mux and the active disable its enable.
// R8 - a commit with select enable copies all staged settings to active ones at once.
// R9 - staging writes leave live routes and enables untouched until a commit.
// R10 - clear with select enable and no disable flag routes every output to input 0.
// R11 - clear with select enable and the disable flag releases every output.
// R12 - each port keeps a staged and an active copy of selection and disable flag.
// R13 - wider variants build each selection from 32-way halves joined on one output.
// R14 - the halves get mutually exclusive enables so only one drives the output.
// R15 - strobes, addresses and flag are taken on a rising edge and act on that edge.
// R16 - output and input addresses are plain binary, 5 bits for 32 ports.
// R17 - a clear updates staged and active copies and wins over a simultaneous commit.
module xb_switch import xb_pkg::*; #(
  parameter int NP = XB_PORTS,
  parameter int FD = XB_FIFO_DEPTH
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [XB_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NP-1:0] din,
  output logic [NP-1:0] dout,
  output logic [NP-1:0] dout_oe
);
  localparam int SW = $clog2(NP);
  localparam int HW = $clog2(XB_HALF);
  localparam int NH = NP / XB_HALF;

  typedef enum logic [1:0] {XB_AP_IDLE, XB_AP_WAIT, XB_AP_DONE} xb_ap_t;

  typedef struct packed {
    logic [NP-1:0][SW-1:0] stg_sel;
    logic [NP-1:0] stg_dis;
    logic [NP-1:0][SW-1:0] act_sel;
    logic [NP-1:0] act_dis;
    logic [NP-1:0] dout;
    logic [NP-1:0] oe;
    logic hold;
    logic [SW-1:0] view;
    xb_ap_t ap;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } xb_state_t;

  xb_state_t r_reg;
  xb_state_t r_next;

  // one-hot decode of a binary port address
  function automatic logic [NP-1:0] port_dec(input logic [SW-1:0] a);
    logic [NP-1:0] d;
    d = '0;
    d[a] = 1'b1;
    return d;
  endfunction : port_dec

  function automatic logic addr_known(input logic [XB_ADDR_W-1:0] a);
    return (a == XB_OFF_CTRL) || (a == XB_OFF_CMD) || (a == XB_OFF_STATUS) ||
           (a == XB_OFF_VIEW) || (a == XB_OFF_ROUTE);
  endfunction : addr_known

  // command path through the fifo
  logic f_in_valid;
  logic f_in_ready;
  logic f_valid;
  logic [31:0] f_data;
  logic [$clog2(FD):0] f_level;
  logic acc_done;
  logic pop;
  logic cs;
  logic c_stage;
  logic c_commit;
  logic c_clear;
  logic c_dis;
  logic [SW-1:0] c_out;
  logic [SW-1:0] c_in;

  assign acc_done = psel && penable && (r_reg.ap == XB_AP_DONE);
  assign f_in_valid = acc_done && pwrite && (paddr == XB_OFF_CMD);
  assign pop = f_valid && !r_reg.hold;
  assign cs = f_data[XB_CMD_CS_BIT];
  assign c_stage = f_data[XB_CMD_STAGE_BIT];
  assign c_commit = f_data[XB_CMD_COMMIT_BIT];
  assign c_clear = f_data[XB_CMD_CLEAR_BIT];
  assign c_dis = f_data[XB_CMD_DIS_BIT];
  assign c_out = f_data[XB_CMD_OUT_LSB +: SW]; // R16
  assign c_in = f_data[XB_CMD_IN_LSB +: SW]; // R16

  xb_fifo #(
    .W(32),
    .D(FD)
  ) u_fifo (
    .clk(pclk),
    .rst_n(presetn),
    .ce(ce),
    .in_valid(f_in_valid),
    .in_ready(f_in_ready),
    .in_data(pwdata),
    .out_valid(f_valid),
    .out_ready(!r_reg.hold),
    .out_data(f_data),
    .level(f_level)
  );

  // switching matrix, one mux per output built from 32-way halves
  logic [NP-1:0] mux_out;
  for (genvar p = 0; p < NP; p++) begin : g_port
    logic [NH-1:0] hval;
    logic [NH-1:0] hen;
    for (genvar h = 0; h < NH; h++) begin : g_half
      assign hen[h] = ((int'(r_reg.act_sel[p]) / XB_HALF) == h); // R13 R14
      assign hval[h] = din[h*XB_HALF + int'(r_reg.act_sel[p][HW-1:0])]; // R2
    end
    assign mux_out[p] = |(hval & hen); // R1 R13

    chk_half_excl: assert property (@(posedge pclk) disable iff (!presetn) $onehot(hen)) // R14
      else $error("mux halves not exclusive");
    chk_route_data: assert property (@(posedge pclk) disable iff (!presetn)
      ce |=> dout[p] == $past(din[r_reg.act_sel[p]])) // R1
      else $error("output bit not from selected input");
    chk_stage_other: assert property (@(posedge pclk) disable iff (!presetn) // R5
      ce && pop && cs && c_stage && !c_clear && c_out != p |=> $stable(r_reg.stg_sel[p]))
      else $error("staging touched another port selection");
    chk_stage_flag_other: assert property (@(posedge pclk) disable iff (!presetn) // R5
      ce && pop && cs && c_stage && !c_clear && c_out != p |=> $stable(r_reg.stg_dis[p]))
      else $error("staging touched another port flag");
  end

  logic [31:0] rd_word;
  always_comb begin
    rd_word = '0;
    case (paddr)
      XB_OFF_CTRL: rd_word[XB_CTRL_HOLD_BIT] = r_reg.hold;
      XB_OFF_STATUS: begin
        rd_word[XB_ST_CNT_LSB +: $clog2(FD)+1] = f_level;
        rd_word[XB_ST_EMPTY_BIT] = !f_valid;
        rd_word[XB_ST_FULL_BIT] = !f_in_ready;
      end
      XB_OFF_VIEW: rd_word[SW-1:0] = r_reg.view;
      XB_OFF_ROUTE: begin
        rd_word[XB_RT_ACT_SEL_LSB +: SW] = r_reg.act_sel[r_reg.view];
        rd_word[XB_RT_ACT_DIS_BIT] = r_reg.act_dis[r_reg.view];
        rd_word[XB_RT_STG_SEL_LSB +: SW] = r_reg.stg_sel[r_reg.view];
        rd_word[XB_RT_STG_DIS_BIT] = r_reg.stg_dis[r_reg.view];
      end
      default: rd_word = '0;
    endcase
  end

  always_comb begin
    logic [NP-1:0] dec;
    dec = port_dec(c_out); // R5
    r_next = r_reg;
    if (pop && cs) begin // R4
      if (c_clear) begin // R17
        for (int p = 0; p < NP; p++) begin
          if (c_dis) begin
            r_next.stg_dis[p] = 1'b1; // R11
            r_next.act_dis[p] = 1'b1; // R11
          end else begin
            r_next.stg_sel[p] = '0; // R10
            r_next.act_sel[p] = '0; // R10
            r_next.stg_dis[p] = 1'b0;
            r_next.act_dis[p] = 1'b0;
          end
        end
      end else begin
        if (c_stage) begin
          for (int p = 0; p < NP; p++) begin
            if (dec[p]) begin
              r_next.stg_sel[p] = c_in; // R6
              r_next.stg_dis[p] = c_dis; // R6
            end
          end
        end
        if (c_commit) begin
          r_next.act_sel = r_next.stg_sel; // R8 R12
          r_next.act_dis = r_next.stg_dis; // R8 R12
        end
      end
    end
    r_next.dout = mux_out; // R2
    r_next.oe = ~r_reg.act_dis; // R3 R7
    // apb slave: answer one cycle into access, hold a command write while the fifo is full
    case (r_reg.ap)
      XB_AP_IDLE, XB_AP_WAIT: begin
        r_next.pready = 1'b0;
        r_next.pslverr = 1'b0;
        if (psel && penable) begin
          if (pwrite && (paddr == XB_OFF_CMD) && !f_in_ready) begin
            r_next.ap = XB_AP_WAIT;
          end else begin
            r_next.ap = XB_AP_DONE;
            r_next.pready = 1'b1;
            r_next.pslverr = !addr_known(paddr);
            r_next.prdata = pwrite ? '0 : rd_word;
          end
        end
      end
      XB_AP_DONE: begin
        r_next.ap = XB_AP_IDLE;
        r_next.pready = 1'b0;
        r_next.pslverr = 1'b0;
        if (acc_done && pwrite) begin
          if (paddr == XB_OFF_CTRL) begin
            r_next.hold = pwdata[XB_CTRL_HOLD_BIT];
          end
          if (paddr == XB_OFF_VIEW) begin
            r_next.view = pwdata[SW-1:0];
          end
        end
      end
      default: begin
        r_next.ap = XB_AP_IDLE;
        r_next.pready = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg.stg_sel <= '0;
      r_reg.stg_dis <= {NP{XB_RST_DIS}};
      r_reg.act_sel <= '0;
      r_reg.act_dis <= {NP{XB_RST_DIS}};
      r_reg.dout <= '0;
      r_reg.oe <= '0;
      r_reg.hold <= XB_RST_HOLD;
      r_reg.view <= '0;
      r_reg.ap <= XB_AP_IDLE;
      r_reg.pready <= 1'b0;
      r_reg.pslverr <= 1'b0;
      r_reg.prdata <= '0;
    end else if (ce) begin
      r_reg <= r_next; // R15
    end
  end

  assign dout = r_reg.dout;
  assign dout_oe = r_reg.oe;
  assign prdata = r_reg.prdata;
  assign pready = r_reg.pready;
  assign pslverr = r_reg.pslverr;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_cs_gate: assert property (ce && pop && !cs |=> // R4
    $stable(r_reg.stg_sel) && $stable(r_reg.act_sel) && $stable(r_reg.act_dis))
    else $error("route changed without select enable");
  chk_stage_write: assert property (ce && pop && cs && c_stage && !c_clear |=> // R5 R6
    r_reg.stg_sel[$past(c_out)] == $past(c_in) && r_reg.stg_dis[$past(c_out)] == $past(c_dis))
    else $error("staged port not written");
  chk_stage_only: assert property (ce && pop && cs && c_stage && !c_commit && !c_clear |=> // R9
    $stable(r_reg.act_sel) && $stable(r_reg.act_dis))
    else $error("live route moved by staging");
  chk_commit_all: assert property (ce && pop && cs && c_commit && !c_stage && !c_clear |=> // R8
    r_reg.act_sel == $past(r_reg.stg_sel) && r_reg.act_dis == $past(r_reg.stg_dis))
    else $error("commit did not copy staged settings");
  chk_bcast_zero: assert property (ce && pop && cs && c_clear && !c_dis |=> // R10 R17
    r_reg.act_sel == '0 && r_reg.stg_sel == '0 && r_reg.act_dis == '0)
    else $error("broadcast clear did not select input 0");
  chk_tri_all: assert property (ce && pop && cs && c_clear && c_dis |=> // R11
    (&r_reg.act_dis && &r_reg.stg_dis) ##1 (!$past(ce) || dout_oe == '0))
    else $error("tri clear did not release outputs");
  chk_oe_follow: assert property (ce |=> dout_oe == ~$past(r_reg.act_dis)) // R7 R3
    else $error("enable not from active disable flag");
  chk_fifo_stall: assert property (psel && penable && pwrite && paddr == XB_OFF_CMD &&
    !f_in_ready && r_reg.ap != XB_AP_DONE |=> !pready)
    else $error("command accepted while fifo full");

  chk_clear_wins: assert property (ce && pop && cs && c_clear && c_commit && !c_dis |=> // R17
    r_reg.act_sel == '0 && r_reg.stg_sel == '0)
    else $error("commit beat a simultaneous clear");
  chk_tri_keep_sel: assert property (ce && pop && cs && c_clear && c_dis |=> // R11
    $stable(r_reg.act_sel) && $stable(r_reg.stg_sel))
    else $error("tri clear moved selections");
  chk_freeze_state: assert property (!ce |=> // R15
    $stable(r_reg) && $stable(f_level))
    else $error("state moved with clock enable low");
  chk_act_only_cmd: assert property (ce && !(pop && cs) |=> // R9
    $stable(r_reg.act_sel) && $stable(r_reg.act_dis))
    else $error("live route moved without a command");
  chk_pready_pulse: assert property (pready |=>
    !pready)
    else $error("ready held longer than one cycle");
  chk_read_answer: assert property (ce && psel && penable && !pwrite && r_reg.ap == XB_AP_IDLE |=>
    pready)
    else $error("read not answered one cycle into access");
  chk_err_unmapped: assert property (pready |->
    pslverr == !addr_known(paddr))
    else $error("error response does not match address map");
  chk_write_rdata: assert property (pready && pwrite |->
    prdata == '0)
    else $error("read data not zero on a write answer");
  chk_no_push_full: assert property (f_in_valid |->
    f_in_ready)
    else $error("command pushed into a full fifo");
  chk_level_max: assert property (f_level <=
    ($clog2(FD)+1)'(FD))
    else $error("fifo level beyond depth");

  cov_stage: cover property (ce && pop && cs && c_stage);
  cov_commit: cover property (ce && pop && cs && c_commit);
  cov_clear: cover property (ce && pop && cs && c_clear);
  cov_full: cover property (!f_in_ready ##1 pready);
  cov_freeze: cover property (!ce ##1 ce);
endmodule : xb_switch

// *** testbench/xb_src_model.sv ***
// far-side data source feeding the switch inputs
// assumes one clock shared with the switch, pattern changes every cycle
`timescale 1ns/1ps

module xb_src_model (
  input wire logic pclk,
  input wire logic presetn,
  output logic [31:0] din
);
  // shift pattern so every input line toggles apart from its neighbours
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      din <= 32'h1357_9bdf;
    end else begin
      din <= {din[30:0], din[31] ^ din[21] ^ din[1] ^ din[0]};
    end
  end
endmodule : xb_src_model

// *** testbench/testbench.sv ***
// self-checking bench for the crossbar switch, apb master tasks and scenarios
// assumes xb_pkg and xb_switch with NP=32, FD=8
`timescale 1ns/1ps

module testbench;
  import xb_pkg::*;
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, err_seen;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, din, dout, dout_oe, prev_din, r;
  int error_cnt = 0;
  int check_count = 0;
  int cyc = 0;

  xb_switch DUT (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .din(din), .dout(dout), .dout_oe(dout_oe));
  xb_src_model src (.pclk(pclk), .presetn(presetn), .din(din));

  initial begin
    pclk = 0;
    forever #50 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    prev_din <= din;
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // command write, then wait until outputs follow
  task automatic cmd(input logic [31:0] d);
    apb(1'b1, XB_OFF_CMD, d);
    repeat (2) @(posedge pclk);
    @(negedge pclk);
  endtask : cmd

  function automatic logic [31:0] rt(input int asel, input int adis, input int ssel, input int sdis);
    return 32'(asel) | 32'(adis << 8) | 32'(ssel << 16) | 32'(sdis << 24);
  endfunction : rt

  task automatic route(input int p, input logic [31:0] exp);
    apb(1'b1, XB_OFF_VIEW, 32'(p));
    apb(1'b0, XB_OFF_ROUTE, 32'h0000_0000);
    chk(r, exp);
  endtask : route

  task automatic t_reset();
    route(5, rt(0, 1, 0, 1));
    chk(dout_oe, 32'h0000_0000);
  endtask : t_reset

  task automatic t_stage();
    cmd(32'h0100_0703);
    route(3, rt(0, 1, 0, 1));
    cmd(32'h8100_0703);
    cmd(32'h8100_0704);
    route(3, rt(0, 1, 7, 0));
    route(2, rt(0, 1, 0, 1));
    chk(dout_oe, 32'h0000_0000);
  endtask : t_stage

  task automatic t_commit();
    cmd(32'h8200_0000);
    chk(dout_oe, 32'h0000_0018);
    route(4, rt(7, 0, 7, 0));
    repeat (4) begin
      @(negedge pclk);
      chk({30'h0, dout[4], dout[3]}, {30'h0, prev_din[7], prev_din[7]});
    end
  endtask : t_commit

  task automatic t_clear();
    cmd(32'h8400_0000);
    chk(dout_oe, 32'hffff_ffff);
    chk(dout, {32{prev_din[0]}});
    route(9, rt(0, 0, 0, 0));
    cmd(32'h8601_0000);
    chk(dout_oe, 32'h0000_0000);
    route(9, rt(0, 1, 0, 1));
  endtask : t_clear

  task automatic t_fifo();
    apb(1'b1, XB_OFF_CTRL, 32'h0000_0001);
    for (int p = 0; p < 7; p++) begin
      apb(1'b1, XB_OFF_CMD, 32'h8100_0000 | 32'(p << 8) | 32'(p));
    end
    apb(1'b1, XB_OFF_CMD, 32'h8200_0000);
    apb(1'b0, XB_OFF_STATUS, 32'h0000_0000);
    chk(r, 32'h0000_0208);
    chk(dout_oe, 32'h0000_0000);
    apb(1'b1, XB_OFF_CTRL, 32'h0000_0000);
    repeat (10) @(posedge pclk);
    apb(1'b0, XB_OFF_STATUS, 32'h0000_0000);
    chk(r, 32'h0000_0100);
    @(negedge pclk);
    chk(dout_oe, 32'h0000_007f);
    apb(1'b0, 8'h40, 32'h0000_0000);
    chk({31'h0, err_seen}, 32'h0000_0001);
  endtask : t_fifo

  // clock enable low must freeze outputs while inputs keep moving
  task automatic t_freeze();
    logic [31:0] held;
    @(posedge pclk);
    ce <= 1'b0;
    @(negedge pclk);
    held = dout;
    repeat (3) @(posedge pclk);
    @(negedge pclk);
    chk(dout, held);
    chk(dout_oe, 32'h0000_007f);
    @(posedge pclk);
    ce <= 1'b1;
  endtask : t_freeze

  initial begin
    presetn = 0;
    ce = 1;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_stage();
    t_commit();
    t_clear();
    t_fifo();
    t_freeze();
    test_done();
  end
endmodule : testbench
